// ### test/sfspr_host_model.sv
// Purpose: host SPI controller model driving the status block
// Assumes: mode 0, 125 ns serial clock, idle low outside frames
// Notes:   frames start just after a falling CLK edge, off the sampling edge
`timescale 1ns/1ps
`default_nettype none
module sfspr_host (
   input  wire logic CLK,
   output var  logic SCLK,
   output var  logic CS_N,
   output var  logic DI,
   input  wire logic DO,
   input  wire logic DO_OE
);
   initial begin
      SCLK = 1'b0;
      CS_N = 1'b1;
      DI   = 1'b0;
   end
   // d is left aligned; rd keeps the last 8 bits seen on the data output
   task automatic frame(input logic [39:0] d, input integer n,
                        output logic [7:0] rd);
      rd = 8'h00;
      @(negedge CLK);
      #2 CS_N = 1'b0;
      for (int i = 0; i < n; i++) begin
         DI = d[39-i];
         #62.5 SCLK = 1'b1;
         rd = {rd[6:0], DO_OE ? DO : 1'bx};
         #62.5 SCLK = 1'b0;
      end
      #62.5 CS_N = 1'b1;
      DI = ~DI;
      #200;
   endtask
endmodule
`default_nettype wire

// ### test/sfspr_status_regs_assertions.sv
// Purpose: pin-level checks on the flash status block
// Assumes: CE held high, only top-level ports visible
// Notes:   op spacing is tracked by a saturating helper counter
`timescale 1ns/1ps
`default_nettype none
module sfspr_status_regs_assertions #(
   parameter integer CYCLE_CLKS = 5000
) (
   input wire logic        CLK,
   input wire logic        RSTN,
   input wire logic        CE,
   input wire logic        SCLK,
   input wire logic        CS_N,
   input wire logic        DI,
   input wire logic        WP_N,
   input wire logic        ERASE_BLOCK_LOCK,
   input wire logic        DO,
   input wire logic        DO_OE,
   input wire logic        PIN_FUNC_EN,
   input wire logic        OP_START,
   input wire logic [2:0]  OP_KIND,
   input wire logic [23:0] OP_ADDR
);
   localparam integer GAP_MIN = CYCLE_CLKS - 2;
   integer since_op;
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN)
         since_op <= CYCLE_CLKS;
      else if (OP_START)
         since_op <= 0;
      else if (since_op < CYCLE_CLKS)
         since_op <= since_op + 1;
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);
   property p_oe_off; CS_N [*6] |-> !DO_OE; endproperty
   property p_oe_rise; $rose(DO_OE) |-> !CS_N; endproperty
   property p_do_edge; DO_OE && $changed(DO) |-> !SCLK; endproperty
   property p_start_cs; OP_START |-> CS_N; endproperty
   property p_start_gap; OP_START |-> since_op >= CYCLE_CLKS; endproperty
   property p_kind_legal; OP_START |-> OP_KIND <= 3'h5; endproperty
   property p_chip_lock;
      OP_START && OP_KIND == 3'h5 |-> !ERASE_BLOCK_LOCK && OP_ADDR == 24'h0;
   endproperty
   property p_pin_func; $changed(PIN_FUNC_EN) |-> since_op >= GAP_MIN;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("data output enabled after deselect");
   a_oe_rise: assert property (p_oe_rise)
      else $error("output enable rose outside a frame");
   a_do_edge: assert property (p_do_edge)
      else $error("data output moved while serial clock high");
   a_start_cs: assert property (p_start_cs)
      else $error("write cycle started while selected");
   a_start_gap: assert property (p_start_gap)
      else $error("write cycle started while busy");
   a_kind_legal: assert property (p_kind_legal)
      else $error("unknown operation kind");
   a_chip_lock: assert property (p_chip_lock)
      else $error("chip erase started under erase lock");
   a_pin_func: assert property (p_pin_func)
      else $error("pin function changed outside cycle end");
   c_chip: cover property (OP_START && OP_KIND == 3'h5);
   c_read: cover property ($rose(DO_OE));
   c_quad: cover property ($fell(PIN_FUNC_EN));
endmodule
bind sfspr_status_regs sfspr_status_regs_assertions #(
   .CYCLE_CLKS(CYCLE_CLKS)
) u_chk (
   .CLK(CLK), .RSTN(RSTN), .CE(CE), .SCLK(SCLK), .CS_N(CS_N),
   .DI(DI), .WP_N(WP_N), .ERASE_BLOCK_LOCK(ERASE_BLOCK_LOCK),
   .DO(DO), .DO_OE(DO_OE), .PIN_FUNC_EN(PIN_FUNC_EN),
   .OP_START(OP_START), .OP_KIND(OP_KIND), .OP_ADDR(OP_ADDR)
);
`default_nettype wire

// ### test/tb_top.sv
// Purpose: self-checking bench for the flash status block
// Assumes: write cycles shortened to CYC clocks so busy stays visible
// Notes:   expected bytes follow the status layout
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam integer CYC = 400;
   logic       clk, rstn, wp_n, erase_block_lock;
   wire        sclk, cs_n, di, do_w, do_oe, pin_en, op_start;
   wire [2:0]  op_kind;
   wire [23:0] op_addr;
   logic [23:0] v, n_ops;
   integer     err_total, n_compared;
   logic [7:0] ops [5] = '{8'h05, 8'h09, 8'h35, 8'h95, 8'h15};
   sfspr_status_regs #(.CYCLE_CLKS(CYC), .ADDR_BITS(21)) u_dut (
      .CLK(clk), .RSTN(rstn), .CE(1'b1), .SCLK(sclk), .CS_N(cs_n),
      .DI(di), .WP_N(wp_n), .ERASE_BLOCK_LOCK(erase_block_lock), .DO(do_w),
      .DO_OE(do_oe), .PIN_FUNC_EN(pin_en), .OP_START(op_start),
      .OP_KIND(op_kind), .OP_ADDR(op_addr));
   sfspr_host u_host (.CLK(clk), .SCLK(sclk), .CS_N(cs_n), .DI(di),
      .DO(do_w), .DO_OE(do_oe));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk or negedge rstn)
      if (!rstn)
         n_ops <= 24'h0;
      else if (op_start)
         n_ops <= n_ops + 24'h1;
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      if (err_total == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic rd(input logic [7:0] op);
      logic [7:0] b;
      u_host.frame({op, 32'h0}, 16, b);
      v = {16'h0, b};
   endtask
   task automatic cmd(input logic [39:0] d, input integer n);
      logic [7:0] b;
      u_host.frame(d, n, b);
   endtask
   task automatic write_latch_set_cmd;
      cmd({8'h06, 32'h0}, 8);
   endtask
   // poll busy before the next command, giving up after ten reads
   task automatic wait_idle;
      for (int i = 0; i < 10; i++) begin
         rd(8'h05);
         if (v[0] === 1'b0)
            return;
      end
      err_total++;
      print_verdict;
   endtask
   initial begin
      err_total = 0;
      n_compared = 0;
      rstn = 1'b0;
      wp_n = 1'b1;
      erase_block_lock = 1'b0;
      repeat (6) @(posedge clk);
      @(negedge clk) rstn = 1'b1;
      repeat (4) @(negedge clk);
      chk({23'h0, pin_en}, 24'h1);
      foreach (ops[i]) begin
         rd(ops[i]);
         chk(v, 24'h0);
      end
      cmd({8'h01, 8'h1C, 8'h00, 16'h0}, 24);
      rd(8'h05);
      chk(v, 24'h00);
      write_latch_set_cmd;
      rd(8'h05);
      chk(v, 24'h02);
      rd(8'h15);
      chk(v, 24'h02);
      cmd({8'h01, 8'h9E, 8'h00, 16'h0}, 24);
      rd(8'h05);
      chk(v, 24'h03);
      chk(n_ops, 24'h1);
      wait_idle;
      rd(8'h05);
      chk(v, 24'h9C);
      @(negedge clk) wp_n = 1'b0;
      write_latch_set_cmd;
      cmd({8'h01, 8'h00, 8'h00, 16'h0}, 24);
      rd(8'h05);
      chk(v, 24'h9E);
      cmd({8'h02, 24'h000100, 8'hA5}, 40);
      chk(n_ops, 24'h1);
      @(negedge clk) wp_n = 1'b1;
      cmd({8'h01, 8'h00, 8'h00, 16'h0}, 24);
      wait_idle;
      rd(8'h05);
      chk(v, 24'h00);
      @(negedge clk) erase_block_lock = 1'b1;
      write_latch_set_cmd;
      cmd({8'hC7, 32'h0}, 8);
      chk(n_ops, 24'h2);
      @(negedge clk) erase_block_lock = 1'b0;
      cmd({8'h60, 32'h0}, 8);
      chk({op_kind, op_addr[20:0]}, {3'h5, 21'h0});
      wait_idle;
      write_latch_set_cmd;
      cmd({8'h20, 24'h001000, 8'h0}, 32);
      chk({op_kind, op_addr[20:0]}, {3'h2, 21'h001000});
      cmd({8'h75, 32'h0}, 8);
      rd(8'h35);
      chk(v, 24'h80);
      rd(8'h05);
      chk(v, 24'h02);
      cmd({8'h7A, 32'h0}, 8);
      rd(8'h09);
      chk(v, 24'h00);
      wait_idle;
      write_latch_set_cmd;
      cmd({8'h02, 24'h000200, 8'h5A}, 40);
      chk({op_kind, op_addr[20:0]}, {3'h1, 21'h000200});
      cmd({8'h75, 32'h0}, 8);
      rd(8'h09);
      chk(v, 24'h04);
      cmd({8'h7A, 32'h0}, 8);
      rd(8'h35);
      chk(v, 24'h00);
      wait_idle;
      write_latch_set_cmd;
      cmd({8'h31, 8'h0A, 24'h0}, 16);
      wait_idle;
      rd(8'h35);
      chk(v, 24'h0A);
      chk({23'h0, pin_en}, 24'h0);
      write_latch_set_cmd;
      cmd({8'h31, 8'h00, 24'h0}, 16);
      wait_idle;
      rd(8'h09);
      chk(v, 24'h08);
      chk({23'h0, pin_en}, 24'h1);
      write_latch_set_cmd;
      cmd({8'h01, 8'h64, 24'h0}, 16);
      wait_idle;
      rd(8'h05);
      chk(v, 24'h64);
      write_latch_set_cmd;
      cmd({8'h20, 24'h000000, 8'h0}, 32);
      chk(n_ops, 24'h8);
      cmd({8'h20, 24'h001000, 8'h0}, 32);
      chk({op_kind, op_addr[20:0]}, {3'h2, 21'h001000});
      wait_idle;
      print_verdict;
   end
endmodule
`default_nettype wire

// ### verilog/sfspr_defs.vh
// Purpose: constants for the serial flash status and protection block
// Assumes: included by its bare name from the block's design file
// Notes:   opcodes are 8 bits, status fields are bit positions
`ifndef SFSPR_DEFS_VH
`define SFSPR_DEFS_VH

`define SFSPR_READ_STATUS_ONE_CMD     8'h05
`define SFSPR_READ_STATUS_TWO_CMD_A   8'h09
`define SFSPR_READ_STATUS_TWO_CMD_B   8'h35
`define SFSPR_READ_STATUS_THREE_CMD_A 8'h95
`define SFSPR_READ_STATUS_THREE_CMD_B 8'h15
`define SFSPR_WRITE_LATCH_SET_CMD     8'h06
`define SFSPR_WRITE_LATCH_CLR_CMD     8'h04
`define SFSPR_STATUS_WRITE_CMD        8'h01
`define SFSPR_STATUS_TWO_WRITE_CMD    8'h31
`define SFSPR_PAGE_PROGRAM_CMD        8'h02
`define SFSPR_QUAD_PAGE_PROGRAM_CMD   8'h32
`define SFSPR_SECTOR_ERASE_CMD        8'h20
`define SFSPR_HALF_BLOCK_ERASE_CMD    8'h52
`define SFSPR_BLOCK_ERASE_CMD         8'hD8
`define SFSPR_CHIP_ERASE_CMD_A        8'hC7
`define SFSPR_CHIP_ERASE_CMD_B        8'h60
`define SFSPR_SUSPEND_CMD             8'h75
`define SFSPR_RESUME_CMD              8'h7A

// first status byte
`define SFSPR_SR1_LOCK   7
`define SFSPR_SR1_GRAN   6
`define SFSPR_SR1_TOPBOT 5
`define SFSPR_SR1_BP_HI  4
`define SFSPR_SR1_BP_LO  2
`define SFSPR_SR1_LATCH  1
`define SFSPR_SR1_BUSY   0
// second status byte
`define SFSPR_ST2_ESUS   7
`define SFSPR_ST2_COMPL  6
`define SFSPR_ST2_SEC_HI 5
`define SFSPR_ST2_SEC_LO 3
`define SFSPR_ST2_PSUS   2
`define SFSPR_ST2_QUAD   1

`define SFSPR_RESET_BYTE 8'h00
`define SFSPR_BLOCK_SHIFT  16
`define SFSPR_SECTOR_SHIFT 12

// write cycle kinds reported on OP_KIND, status write and array operations
`define SFSPR_OP_STATUS  3'h0
`define SFSPR_OP_PROGRAM 3'h1
`define SFSPR_OP_SECTOR  3'h2
`define SFSPR_OP_HALF    3'h3
`define SFSPR_OP_BLOCK   3'h4
`define SFSPR_OP_CHIP    3'h5

`endif

// ### verilog/sfspr_status_regs.v
// Purpose: status/protection registers of a serial flash behind its SPI pins
// Assumes: SPI mode 0, SCLK well below CLK/4, all pins asynchronous
// Notes:   self-timed cycles are modelled by a cycle counter
//
// Overview of operation
// - first status byte readable anytime, even busy
// - byte one: lock,gran,topbot,protect[2:0],latch,busy
// - busy high exactly while a write cycle runs
// - clear write latch refuses writes, program, erase
// - lock with protect pin low freezes status
// - otherwise status stays writable
// - top/bottom picks protected end, default top
// - granularity bit selects sector or block units
// - protected region refuses program and erase
// - chip erase needs nothing protected, erase lock clear
// - second byte readable by both opcodes anytime
// - byte two: esus,complement,locks[2:0],psus,quad,zero
// - reserved lowest bit reads zero
// - erase suspend flag set on suspend, clear resume
// - program suspend flag set on suspend, clear resume
// - complement bit inverts protected region
// - security locks one-time set, later writes cannot clear them
// - quad enable disables protect and hold pins
// - volatile bits reset to zero
// - third byte readable by both opcodes anytime
// - status shifted out most significant first
// - write latch cleared when write cycle completes
`timescale 1ns/1ps
`default_nettype none
`include "sfspr_defs.vh"

module sfspr_status_regs #(
   parameter integer CYCLE_CLKS = 5000,
   parameter integer ADDR_BITS  = 21
) (
   input  wire        CLK,
   input  wire        RSTN,
   input  wire        CE,
   input  wire        SCLK,
   input  wire        CS_N,
   input  wire        DI,
   input  wire        WP_N,
   input  wire        ERASE_BLOCK_LOCK,
   output reg         DO,
   output wire        DO_OE,
   output wire        PIN_FUNC_EN,
   output reg         OP_START,
   output reg  [2:0]  OP_KIND,
   output reg  [23:0] OP_ADDR
);

   reg  [1:0]  sclk_s, cs_s, di_s, wp_s;
   reg         sclk_d, cs_d;
   reg  [5:0]  bit_cnt;
   reg  [31:0] shift_in;
   reg  [7:0]  opcode;
   reg  [2:0]  rd_idx;
   reg         rd_act;
   reg  [7:0]  sr1;
   reg  [7:0]  stat_two;
   reg  [23:0] addr_q;
   reg  [31:0] timer;
   reg  [2:0]  cur_kind;
   reg  [7:0]  pend1, pend2;
   reg         pend2_ok;

   wire sclk_rise = sclk_s[1] & ~sclk_d;
   wire sclk_fall = ~sclk_s[1] & sclk_d;
   wire cs_rise   = cs_s[1] & ~cs_d;
   wire selected  = ~cs_s[1];
   wire busy      = sr1[`SFSPR_SR1_BUSY];
   wire latch     = sr1[`SFSPR_SR1_LATCH];
   wire [2:0] bp  = sr1[`SFSPR_SR1_BP_HI:`SFSPR_SR1_BP_LO];
   wire compl_bit = stat_two[`SFSPR_ST2_COMPL];
   wire quad_en   = stat_two[`SFSPR_ST2_QUAD];
   // with quad enable set the protect pin is ignored, reads as high
   wire wp_low    = ~wp_s[1] & ~quad_en;
   wire hw_prot   = sr1[`SFSPR_SR1_LOCK] & wp_low;
   wire [7:0] sr3 = {6'h00, sr1[`SFSPR_SR1_LATCH], sr1[`SFSPR_SR1_BUSY]};
   wire [23:0] addr = addr_q;
   wire [7:0] last_op = (bit_cnt == 6'd8) ? shift_in[7:0] : opcode;

   assign PIN_FUNC_EN = ~quad_en;
   assign DO_OE       = rd_act & selected;

   // protected test for one address; table kept to the plain power-of-two
   // form so that the effect of each field stays visible
   function prot_hit;
      input [23:0] a;
      input [7:0]  s1;
      input        c;
      reg   [11:0] idx;
      reg   [11:0] rel;
      reg   [11:0] last;
      reg   [11:0] n;
      reg          base;
      begin
         if (s1[`SFSPR_SR1_GRAN]) begin
            idx  = a[`SFSPR_SECTOR_SHIFT +: 12];
            last = 12'hFFF >> (12 - (ADDR_BITS - `SFSPR_SECTOR_SHIFT));
         end else begin
            idx  = {8'h00, a[`SFSPR_BLOCK_SHIFT +: 4]} |
                   {7'h00, a[20], 4'h0};
            last = 12'hFFF >> (12 - (ADDR_BITS - `SFSPR_BLOCK_SHIFT));
         end
         idx  = idx & last;
         rel  = s1[`SFSPR_SR1_TOPBOT] ? idx : (last - idx);
         n    = 12'h001 << (s1[4:2] - 3'd1);
         if (s1[4:2] == 3'd0)
            base = 1'b0;
         else if (s1[4:2] == 3'd7)
            base = 1'b1;
         else
            base = (rel < n);
         prot_hit = base ^ c;
      end
   endfunction

   wire addr_prot = prot_hit(addr, sr1, compl_bit);
   wire none_prot = compl_bit ? (bp == 3'd7) : (bp == 3'd0);
   wire write_ok  = latch & ~busy;
   wire is_prog   = (opcode == `SFSPR_PAGE_PROGRAM_CMD) |
                    (opcode == `SFSPR_QUAD_PAGE_PROGRAM_CMD);
   wire is_erase  = (opcode == `SFSPR_SECTOR_ERASE_CMD) |
                    (opcode == `SFSPR_HALF_BLOCK_ERASE_CMD) |
                    (opcode == `SFSPR_BLOCK_ERASE_CMD);
   wire is_chip   = (opcode == `SFSPR_CHIP_ERASE_CMD_A) |
                    (opcode == `SFSPR_CHIP_ERASE_CMD_B);

   reg [2:0] erase_kind;
   always @* begin
      case (opcode)
         `SFSPR_SECTOR_ERASE_CMD:     erase_kind = `SFSPR_OP_SECTOR;
         `SFSPR_HALF_BLOCK_ERASE_CMD: erase_kind = `SFSPR_OP_HALF;
         default:                     erase_kind = `SFSPR_OP_BLOCK;
      endcase
   end

   reg [7:0] rd_byte;
   always @* begin
      case (opcode)
         `SFSPR_READ_STATUS_ONE_CMD:     rd_byte = sr1;
         `SFSPR_READ_STATUS_TWO_CMD_A,
         `SFSPR_READ_STATUS_TWO_CMD_B:
            rd_byte = {stat_two[7:1], 1'b0};
         `SFSPR_READ_STATUS_THREE_CMD_A,
         `SFSPR_READ_STATUS_THREE_CMD_B: rd_byte = sr3;
         default:                        rd_byte = 8'h00;
      endcase
   end

   wire is_read = (last_op == `SFSPR_READ_STATUS_ONE_CMD) |
                  (last_op == `SFSPR_READ_STATUS_TWO_CMD_A) |
                  (last_op == `SFSPR_READ_STATUS_TWO_CMD_B) |
                  (last_op == `SFSPR_READ_STATUS_THREE_CMD_A) |
                  (last_op == `SFSPR_READ_STATUS_THREE_CMD_B);

   // serial and protect pins come from outside: two flops before anything reads them; ERASE_BLOCK_LOCK is used unsynchronised
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sclk_s <= 2'b00;
         cs_s   <= 2'b11;
         di_s   <= 2'b00;
         wp_s   <= 2'b11;
         sclk_d <= 1'b0;
         cs_d   <= 1'b1;
      end else if (CE) begin
         sclk_s <= {sclk_s[0], SCLK};
         cs_s   <= {cs_s[0], CS_N};
         di_s   <= {di_s[0], DI};
         wp_s   <= {wp_s[0], WP_N};
         sclk_d <= sclk_s[1];
         cs_d   <= cs_s[1];
      end
   end

   // serial front end: sample on rising edge, shift out on falling edge
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         bit_cnt  <= 6'd0;
         shift_in <= 32'h0000_0000;
         opcode   <= 8'h00;
         addr_q   <= 24'h000000;
         rd_act   <= 1'b0;
         rd_idx   <= 3'd0;
         DO       <= 1'b0;
      end else if (CE) begin
         if (!selected) begin
            bit_cnt <= 6'd0;
            rd_act  <= 1'b0;
            rd_idx  <= 3'd0;
         end else begin
            if (sclk_rise) begin
               shift_in <= {shift_in[30:0], di_s[1]};
               if (bit_cnt != 6'h3F)
                  bit_cnt <= bit_cnt + 6'd1;
               if (bit_cnt == 6'd7)
                  opcode <= {shift_in[6:0], di_s[1]};
               if (bit_cnt == 6'd31)
                  addr_q <= {shift_in[22:0], di_s[1]};
            end
            if (bit_cnt == 6'd8 && !rd_act && is_read) begin
               rd_act <= 1'b1;
               opcode <= shift_in[7:0];
            end
            if (sclk_fall && rd_act) begin
               DO     <= rd_byte[~rd_idx];
               rd_idx <= rd_idx + 3'd1;
            end
         end
      end
   end

   // command execution at select release, and the self-timed cycle
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sr1      <= `SFSPR_RESET_BYTE;
         stat_two <= `SFSPR_RESET_BYTE;
         timer    <= 32'd0;
         cur_kind <= `SFSPR_OP_STATUS;
         pend1    <= 8'h00;
         pend2    <= 8'h00;
         pend2_ok <= 1'b0;
         OP_START <= 1'b0;
         OP_KIND  <= `SFSPR_OP_STATUS;
         OP_ADDR  <= 24'h000000;
      end else if (CE) begin
         OP_START <= 1'b0;
         if (busy) begin
            if (timer == 32'd0) begin
               sr1[`SFSPR_SR1_BUSY] <= 1'b0;
               sr1[`SFSPR_SR1_LATCH] <= 1'b0;
               if (cur_kind == `SFSPR_OP_STATUS) begin
                  sr1[7:2] <= pend1[7:2];
                  if (pend2_ok) begin
                     stat_two[`SFSPR_ST2_COMPL] <= pend2[`SFSPR_ST2_COMPL];
                     stat_two[`SFSPR_ST2_QUAD]  <= pend2[`SFSPR_ST2_QUAD];
                     // locks only ever go from 0 to 1
                     stat_two[5:3] <= stat_two[5:3] | pend2[5:3];
                  end
               end
            end else begin
               timer <= timer - 32'd1;
            end
         end
         if (cs_rise) begin
            case (opcode)
               `SFSPR_WRITE_LATCH_SET_CMD:
                  if (!busy && bit_cnt == 6'd8)
                     sr1[`SFSPR_SR1_LATCH] <= 1'b1;
               `SFSPR_WRITE_LATCH_CLR_CMD:
                  if (!busy && bit_cnt == 6'd8)
                     sr1[`SFSPR_SR1_LATCH] <= 1'b0;
               `SFSPR_STATUS_WRITE_CMD,
               `SFSPR_STATUS_TWO_WRITE_CMD:
                  if (write_ok && !hw_prot &&
                      (bit_cnt == 6'd16 ||
                       (opcode == `SFSPR_STATUS_WRITE_CMD &&
                        (bit_cnt == 6'd24 || bit_cnt == 6'd32)))) begin
                     sr1[`SFSPR_SR1_BUSY] <= 1'b1;
                     timer    <= CYCLE_CLKS - 1;
                     cur_kind <= `SFSPR_OP_STATUS;
                     OP_START <= 1'b1;
                     OP_KIND  <= `SFSPR_OP_STATUS;
                     if (opcode == `SFSPR_STATUS_TWO_WRITE_CMD) begin
                        pend1    <= sr1;
                        pend2    <= shift_in[7:0];
                        pend2_ok <= 1'b1;
                     end else if (bit_cnt == 6'd16) begin
                        pend1    <= shift_in[7:0];
                        pend2_ok <= 1'b0;
                     end else if (bit_cnt == 6'd24) begin
                        pend1    <= shift_in[15:8];
                        pend2    <= shift_in[7:0];
                        pend2_ok <= 1'b1;
                     end else begin
                        pend1    <= shift_in[23:16];
                        pend2    <= shift_in[15:8];
                        pend2_ok <= 1'b1;
                     end
                  end
               `SFSPR_SUSPEND_CMD:
                  if (busy && timer != 32'd0 &&
                      cur_kind != `SFSPR_OP_STATUS && bit_cnt == 6'd8) begin
                     sr1[`SFSPR_SR1_BUSY] <= 1'b0;
                     if (cur_kind == `SFSPR_OP_PROGRAM)
                        stat_two[`SFSPR_ST2_PSUS] <= 1'b1;
                     else
                        stat_two[`SFSPR_ST2_ESUS] <= 1'b1;
                  end
               `SFSPR_RESUME_CMD:
                  if (!busy && bit_cnt == 6'd8 &&
                      (stat_two[`SFSPR_ST2_PSUS] |
                       stat_two[`SFSPR_ST2_ESUS])) begin
                     sr1[`SFSPR_SR1_BUSY] <= 1'b1;
                     stat_two[`SFSPR_ST2_PSUS] <= 1'b0;
                     stat_two[`SFSPR_ST2_ESUS] <= 1'b0;
                  end
               default: begin
                  if (is_prog && write_ok && bit_cnt >= 6'd40 &&
                      bit_cnt[2:0] == 3'd0 && !addr_prot) begin
                     sr1[`SFSPR_SR1_BUSY] <= 1'b1;
                     timer    <= CYCLE_CLKS - 1;
                     cur_kind <= `SFSPR_OP_PROGRAM;
                     OP_START <= 1'b1;
                     OP_KIND  <= `SFSPR_OP_PROGRAM;
                     OP_ADDR  <= addr;
                  end
                  if (is_erase && write_ok && bit_cnt == 6'd32 &&
                      !addr_prot) begin
                     sr1[`SFSPR_SR1_BUSY] <= 1'b1;
                     timer    <= CYCLE_CLKS - 1;
                     cur_kind <= erase_kind;
                     OP_START <= 1'b1;
                     OP_KIND  <= erase_kind;
                     OP_ADDR  <= addr;
                  end
                  if (is_chip && write_ok && bit_cnt == 6'd8 &&
                      none_prot && !ERASE_BLOCK_LOCK) begin
                     sr1[`SFSPR_SR1_BUSY] <= 1'b1;
                     timer    <= CYCLE_CLKS - 1;
                     cur_kind <= `SFSPR_OP_CHIP;
                     OP_START <= 1'b1;
                     OP_KIND  <= `SFSPR_OP_CHIP;
                     OP_ADDR  <= 24'h000000;
                  end
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire
